// ### lpc_bar_decode.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - config port io base moves by writing unit twelve host field; default 002E
// RULE2 - every io decode register resets to its unit default value
// RULE3 - legacy units claim by their own fixed range, not register frame/mask
// RULE4 - memory decode registers live in the config space of unit 0Ch
// RULE5 - memory decode registers are 48 bits: host, valid, slot, ignore
// RULE6 - claimed memory cycle becomes one 8-bit ahb transfer, 24-bit address
// RULE7 - bits 47:16 hold the 32-bit host memory match address
// RULE8 - memory decode register matches only while bit 15 is set
// RULE9 - slot number times 400h gives the unit frame address
// RULE10 - bits 7:0 pick host address bits left out of the compare
// RULE11 - slot and ignore fields read-only except for unit 3h
// RULE12 - memory decode registers reset to their listed defaults
// RULE13 - config port registers reachable only through host io cycles
// RULE14 - pointer at base +00h, window at next byte
// RULE15 - host writes pointer; device holds it to select the target register
// RULE16 - window reads and writes reach the register the pointer selects
// RULE17 - config space reached through pointer/window only in setup state
// RULE18 - all io decode registers compared in parallel; any match claims
// RULE19 - config port host field: low byte shadowed, high byte updates all
// RULE20 - a set ignore bit drops that low bit, claiming a block up to 256
module lpc_bar_decode (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_host_side_reset_n,
  input  wire logic        i_lclk,
  input  wire logic        i_lframe_n,
  input  wire logic [3:0]  i_lad,
  output logic      [3:0]  o_lad,
  output logic             o_lad_oe,
  output logic      [23:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [7:0]  o_hwdata,
  input  wire logic [7:0]  i_hrdata,
  input  wire logic        i_hready,
  output logic             o_setup_active
);

  // ==========================================================
  // state
  typedef struct packed {
    lpc_bar_pkg::lpc_pins_t                          s1;
    lpc_bar_pkg::lpc_pins_t                          s2;
    lpc_bar_pkg::lpc_pins_t                          s3;
    lpc_bar_pkg::lpc_pins_t                          f;
    lpc_bar_pkg::lpc_st_t                            st;
    logic                                            mem;
    logic                                            wr;
    logic [2:0]                                      cnt;
    logic [31:0]                                     addr;
    logic [7:0]                                      dat;
    logic                                            lad_oe;
    logic [3:0]                                      lad_o;
    logic [lpc_bar_pkg::N_IO-1:0][31:0]              io;
    logic [lpc_bar_pkg::N_MEM-1:0][47:0]             mb;
    logic [7:0]                                      shadow;
    logic [7:0]                                      ptr;
    logic                                            setup;
    lpc_bar_pkg::ahb_ph_t                            ph;
    logic [1:0]                                      htrans;
    lpc_bar_pkg::ahb_req_t                           req;
  } state_t;

  state_t r, n;
  logic   rise, io_hit, mem_hit, hit, cfg_sel, cfg_hi_wr, ptr_wr, win_wr;
  logic [5:0] sel_frame;
  logic [7:0] sel_off;

  // ==========================================================
  // helpers
  // compare with ignored low bits
  function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                     input logic [7:0] ign);
    return ((a ^ b) & ~{24'h000000, ign}) == 32'h00000000; // RULE20 RULE10
  endfunction

  // internal address: unit frame scaled by 400h plus offset
  function automatic logic [23:0] ahb_addr(input logic [5:0] fr, input logic [7:0] off);
    return {8'h00, fr, 2'b00, off}; // RULE9
  endfunction

  // config space read: io decode bytes then memory decode bytes
  function automatic logic [7:0] cfg_rd(input state_t s, input logic [7:0] p);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < lpc_bar_pkg::N_IO; i++) begin
      for (int b = 0; b < 4; b++) begin
        if (p == lpc_bar_pkg::IO_OFS[i] + 8'(b)) begin
          d = s.io[i][8*b +: 8];
        end
      end
    end
    for (int j = 0; j < lpc_bar_pkg::N_MEM; j++) begin
      for (int b = 0; b < 6; b++) begin
        if (p == lpc_bar_pkg::MEM_OFS[j] + 8'(b)) begin
          d = s.mb[j][8*b +: 8]; // RULE4
        end
      end
    end
    return d;
  endfunction

  // reset image for the main power reset
  function automatic state_t st_rst();
    state_t s;
    s = '0;
    s.st = lpc_bar_pkg::S_IDLE;
    s.ph = lpc_bar_pkg::PH_IDLE;
    s.io = lpc_bar_pkg::IO_RST; // RULE2
    s.mb = lpc_bar_pkg::MEM_RST; // RULE12
    s.ptr = lpc_bar_pkg::PTR_RST;
    s.lad_o = lpc_bar_pkg::NIB_TAR;
    s.htrans = lpc_bar_pkg::HT_IDLE;
    return s;
  endfunction

  // ==========================================================
  // address decode: io decode registers checked in parallel, memory decode registers too on memory cycles
  always_comb begin
    io_hit = 1'b0;
    mem_hit = 1'b0;
    cfg_sel = 1'b0;
    sel_frame = 6'h00;
    sel_off = 8'h00;
    for (int i = lpc_bar_pkg::N_IO - 1; i >= 0; i--) begin
      // legacy units keep their own fixed range, the config port uses its field
      if (i == lpc_bar_pkg::CFG_UNIT) begin
        if (masked_eq({16'h0000, r.addr[15:0]}, {16'h0000, r.io[i][31:16]},
                      r.io[i][7:0])) begin
          io_hit = 1'b1; // RULE18 RULE1 RULE14
          cfg_sel = 1'b1;
        end
      end else if (r.io[i][lpc_bar_pkg::VALID_BIT] &&
                   masked_eq({16'h0000, r.addr[15:0]}, {16'h0000, r.io[i][31:16]},
                             lpc_bar_pkg::IO_RST[i][7:0])) begin
        io_hit = 1'b1; // RULE18 RULE3
        cfg_sel = 1'b0;
        sel_frame = r.io[i][13:8];
        sel_off = r.addr[7:0] & lpc_bar_pkg::IO_RST[i][7:0];
      end
    end
    if (r.mem) begin
      cfg_sel = 1'b0;
      for (int j = lpc_bar_pkg::N_MEM - 1; j >= 0; j--) begin
        if (r.mb[j][lpc_bar_pkg::VALID_BIT] &&
            masked_eq(r.addr, r.mb[j][47:16], r.mb[j][7:0])) begin
          mem_hit = 1'b1; // RULE8 RULE7 RULE5
          sel_frame = r.mb[j][13:8];
          sel_off = r.addr[7:0] & r.mb[j][7:0];
        end
      end
    end
    hit = r.mem ? mem_hit : io_hit; // RULE13
  end

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    cfg_hi_wr = 1'b0;
    ptr_wr = 1'b0;
    win_wr = 1'b0;
    // three-stage pin sampling; a bit moves once stages two and three agree
    n.s1 = {i_host_side_reset_n, i_lclk, i_lframe_n, i_lad};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
    rise = !r.f.clk && n.f.clk;

    // ahb engine: one address phase, then wait out the data phase
    case (r.ph)
      lpc_bar_pkg::PH_ADDR: begin
        if (i_hready) begin
          n.htrans = lpc_bar_pkg::HT_IDLE;
          n.ph = lpc_bar_pkg::PH_DATA; // RULE6
        end
      end
      lpc_bar_pkg::PH_DATA: begin
        if (i_hready) begin
          n.ph = lpc_bar_pkg::PH_IDLE;
          if (!r.req.write) begin
            n.dat = i_hrdata;
          end
        end
      end
      default: ;
    endcase

    if (!r.f.rst_n) begin
      // host side reset: reload memory decode and config port base, drop cycle
      n.mb = lpc_bar_pkg::MEM_RST; // RULE12
      n.io[lpc_bar_pkg::CFG_UNIT][31:16] = lpc_bar_pkg::CFG_HOST_RST; // RULE1
      n.st = lpc_bar_pkg::S_IDLE;
      n.lad_oe = 1'b0;
      n.setup = 1'b0;
    end else if (rise && !r.f.frame_n) begin
      // frame low restarts or aborts the lpc cycle in flight, not the internal transfer
      n.lad_oe = 1'b0;
      n.st = (r.f.lad == lpc_bar_pkg::NIB_START) ? lpc_bar_pkg::S_CYC
                                                 : lpc_bar_pkg::S_IDLE;
    end else if (rise) begin
      case (r.st)
        lpc_bar_pkg::S_CYC: begin
          n.mem = r.f.lad[2];
          n.wr = r.f.lad[1];
          n.addr = 32'h00000000;
          n.cnt = r.f.lad[2] ? lpc_bar_pkg::ADDR_NIB_MEM : lpc_bar_pkg::ADDR_NIB_IO;
          n.st = (!r.f.lad[3] && !r.f.lad[0]) ? lpc_bar_pkg::S_ADDR
                                              : lpc_bar_pkg::S_IDLE;
        end
        lpc_bar_pkg::S_ADDR: begin
          n.addr = {r.addr[27:0], r.f.lad};
          n.cnt = r.cnt - 3'h1;
          if (r.cnt == 3'h0) begin
            n.cnt = 3'h1;
            n.st = r.wr ? lpc_bar_pkg::S_WDATA : lpc_bar_pkg::S_TAR1;
          end
        end
        lpc_bar_pkg::S_WDATA: begin
          n.dat = {r.f.lad, r.dat[7:4]};
          n.cnt = r.cnt - 3'h1;
          if (r.cnt == 3'h0) begin
            n.st = lpc_bar_pkg::S_TAR1;
          end
        end
        lpc_bar_pkg::S_TAR1: begin
          if (!hit) begin
            n.st = lpc_bar_pkg::S_IDLE;
          end else begin
            n.st = lpc_bar_pkg::S_TAR2;
            n.lad_oe = 1'b1;
            n.lad_o = lpc_bar_pkg::NIB_TAR;
            if (cfg_sel && !r.addr[0]) begin
              // pointer register
              if (r.wr) begin
                ptr_wr = 1'b1;
                n.ptr = r.dat; // RULE15 RULE14
                if (r.dat == lpc_bar_pkg::SETUP_ENTER) begin
                  n.setup = 1'b1;
                end else if (r.dat == lpc_bar_pkg::SETUP_EXIT) begin
                  n.setup = 1'b0;
                end
              end else begin
                n.dat = r.ptr;
              end
            end else if (cfg_sel) begin
              // window register, live only in the setup state
              if (!r.wr) begin
                n.dat = r.setup ? cfg_rd(r, r.ptr) : 8'h00; // RULE16 RULE17
              end else if (r.setup) begin
                win_wr = 1'b1; // RULE16 RULE17
                for (int i = 0; i < lpc_bar_pkg::N_IO; i++) begin
                  if (r.ptr == lpc_bar_pkg::IO_OFS[i] + 8'h1) begin
                    n.io[i][lpc_bar_pkg::VALID_BIT] = r.dat[7];
                  end else if (r.ptr == lpc_bar_pkg::IO_OFS[i] + 8'h2) begin
                    if (i == lpc_bar_pkg::CFG_UNIT) begin
                      n.shadow = r.dat; // RULE19
                    end else begin
                      n.io[i][23:16] = r.dat;
                    end
                  end else if (r.ptr == lpc_bar_pkg::IO_OFS[i] + 8'h3) begin
                    if (i == lpc_bar_pkg::CFG_UNIT) begin
                      cfg_hi_wr = 1'b1;
                      n.io[i][31:16] = {r.dat, r.shadow}; // RULE19 RULE1
                    end else begin
                      n.io[i][31:24] = r.dat;
                    end
                  end
                end
                for (int j = 0; j < lpc_bar_pkg::N_MEM; j++) begin
                  for (int b = 2; b < 6; b++) begin
                    if (r.ptr == lpc_bar_pkg::MEM_OFS[j] + 8'(b)) begin
                      n.mb[j][8*b +: 8] = r.dat; // RULE7 RULE4
                    end
                  end
                  if (r.ptr == lpc_bar_pkg::MEM_OFS[j] + 8'h1) begin
                    n.mb[j][lpc_bar_pkg::VALID_BIT] = r.dat[7];
                    if (j == lpc_bar_pkg::MEM_WR_UNIT) begin
                      n.mb[j][13:8] = r.dat[5:0]; // RULE11
                    end
                  end else if (r.ptr == lpc_bar_pkg::MEM_OFS[j] &&
                               j == lpc_bar_pkg::MEM_WR_UNIT) begin
                    n.mb[j][7:0] = r.dat; // RULE11
                  end
                end
              end
            end else begin
              // hand the claimed cycle to the internal bus as one byte
              n.req.addr = ahb_addr(sel_frame, sel_off); // RULE6 RULE9
              n.req.write = r.wr;
              n.req.wdata = r.dat;
              n.ph = lpc_bar_pkg::PH_ADDR;
              n.htrans = lpc_bar_pkg::HT_NONSEQ;
            end
          end
        end
        lpc_bar_pkg::S_TAR2: begin
          n.lad_o = (r.ph != lpc_bar_pkg::PH_IDLE) ? lpc_bar_pkg::SYNC_LWAIT
                                                   : lpc_bar_pkg::SYNC_READY;
          n.st = lpc_bar_pkg::S_SYNC;
        end
        lpc_bar_pkg::S_SYNC: begin
          // long wait repeats until the internal transfer is done
          if (r.lad_o == lpc_bar_pkg::SYNC_LWAIT) begin
            n.lad_o = (r.ph != lpc_bar_pkg::PH_IDLE) ? lpc_bar_pkg::SYNC_LWAIT
                                                     : lpc_bar_pkg::SYNC_READY;
          end else if (!r.wr) begin
            n.lad_o = r.dat[3:0];
            n.cnt = 3'h1;
            n.st = lpc_bar_pkg::S_RDATA;
          end else begin
            n.lad_o = lpc_bar_pkg::NIB_TAR;
            n.st = lpc_bar_pkg::S_TEND;
          end
        end
        lpc_bar_pkg::S_RDATA: begin
          if (r.cnt == 3'h1) begin
            n.lad_o = r.dat[7:4];
            n.cnt = 3'h0;
          end else begin
            n.lad_o = lpc_bar_pkg::NIB_TAR;
            n.st = lpc_bar_pkg::S_TEND;
          end
        end
        lpc_bar_pkg::S_TEND: begin
          n.lad_oe = 1'b0;
          n.st = lpc_bar_pkg::S_IDLE;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // state register; main power reset restores everything
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r <= st_rst();
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops, except hsize which is the constant byte size
  assign o_lad = r.lad_o;
  assign o_lad_oe = r.lad_oe;
  assign o_haddr = r.req.addr;
  assign o_htrans = r.htrans;
  assign o_hwrite = r.req.write;
  assign o_hsize = lpc_bar_pkg::HSIZE_BYTE;
  assign o_hwdata = r.req.wdata;
  assign o_setup_active = r.setup;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_io_reset_vals: assert property ($past(i_rst) |-> r.io == lpc_bar_pkg::IO_RST) // RULE2
    else $error("io decode registers not at reset values");
  a_mem_reset_vals: assert property ($past(i_rst) |-> r.mb == lpc_bar_pkg::MEM_RST) // RULE12
    else $error("memory decode registers not at reset values");
  a_cfg_base_reload: assert property (!$past(r.f.rst_n) && !$past(i_rst) |->
    r.io[0][31:16] == lpc_bar_pkg::CFG_HOST_RST) // RULE1
    else $error("config port base not reloaded by host side reset");
  a_shadow_update: assert property ($changed(r.io[0][31:16]) && $past(r.f.rst_n) &&
    !$past(i_rst) |-> $past(cfg_hi_wr)) // RULE19
    else $error("config port base changed without a high byte write");
  a_claim_on_hit: assert property ($rose(r.lad_oe) |-> $past(hit) && $past(r.st) ==
    lpc_bar_pkg::S_TAR1) // RULE18
    else $error("bus driven without an address match");
  a_ahb_one_beat: assert property ($rose(r.ph == lpc_bar_pkg::PH_ADDR) |-> // RULE6
    r.htrans == lpc_bar_pkg::HT_NONSEQ ##[1:1000]
    (r.htrans == lpc_bar_pkg::HT_IDLE && r.ph == lpc_bar_pkg::PH_DATA))
    else $error("internal transfer not a single beat");
  a_window_setup: assert property (win_wr |-> r.setup ##1 $past(r.ptr) == r.ptr) // RULE17
    else $error("window write outside setup state");
  // unit registers other than the port base may only move through the window
  a_window_locked: assert property (!r.setup |=> $stable(r.io[lpc_bar_pkg::N_IO-1:1])) // RULE17
    else $error("io decode register written outside setup state");
  a_ptr_hold: assert property ($changed(r.ptr) && !$past(i_rst) |-> $past(ptr_wr)) // RULE15
    else $error("pointer changed without a pointer write");
  a_mem_fields_ro: assert property (r.mb[3][13:0] == lpc_bar_pkg::MEM_RST[3][13:0] && // RULE11
    r.mb[2][13:0] == lpc_bar_pkg::MEM_RST[2][13:0] &&
    r.mb[0][13:0] == lpc_bar_pkg::MEM_RST[0][13:0])
    else $error("read-only memory decode field changed");

endmodule // lpc_bar_decode

// ### lpc_bar_pkg.sv
package lpc_bar_pkg;
  // ==========================================================
  // unit tables (index 0 of the io tables is the config port)
  localparam int N_IO        = 10;
  localparam int N_MEM       = 4;
  localparam int CFG_UNIT    = 0;
  localparam int MEM_WR_UNIT = 1;  // memory decode entry of host ec channel 0
  localparam logic [N_IO-1:0][7:0] IO_OFS = {8'h9c, 8'h98, 8'h94, 8'h90, 8'h8c,
                                             8'h88, 8'h78, 8'h68, 8'h64, 8'h60};
  localparam logic [N_IO-1:0][31:0] IO_RST = {
    32'h00000b3f, 32'h00000901, 32'h00920600, 32'h00000507, 32'h00660407,
    32'h00620304, 32'h00600104, 32'h00000707, 32'h0000000f, 32'h002e0c01};
  localparam logic [N_MEM-1:0][7:0]  MEM_OFS = {8'hd2, 8'hcc, 8'hc6, 8'hc0};
  localparam logic [N_MEM-1:0][47:0] MEM_RST = {
    48'h00000000000f, 48'h000000660407, 48'h000000620304, 48'h000000000901};
  localparam logic [15:0] CFG_HOST_RST = 16'h002e;
  localparam logic [7:0]  PTR_RST      = 8'h00;

  // ==========================================================
  // field positions of a decode register
  localparam int VALID_BIT = 15;
  localparam int IO_HOST_LSB = 16;
  localparam int MEM_HOST_LSB = 16;

  // ==========================================================
  // config port and bus codes
  localparam logic [7:0] SETUP_ENTER  = 8'h55;
  localparam logic [7:0] SETUP_EXIT   = 8'haa;
  localparam logic [3:0] NIB_START    = 4'h0;
  localparam logic [3:0] NIB_TAR      = 4'hf;
  localparam logic [3:0] SYNC_READY   = 4'h0;
  localparam logic [3:0] SYNC_LWAIT   = 4'h6;
  localparam logic [2:0] ADDR_NIB_IO  = 3'h3;
  localparam logic [2:0] ADDR_NIB_MEM = 3'h7;
  localparam logic [1:0] HT_IDLE      = 2'h0;
  localparam logic [1:0] HT_NONSEQ    = 2'h2;
  localparam logic [2:0] HSIZE_BYTE   = 3'h0;

  typedef enum logic [3:0] {S_IDLE, S_CYC, S_ADDR, S_WDATA, S_TAR1, S_TAR2,
                            S_SYNC, S_RDATA, S_TEND} lpc_st_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} ahb_ph_t;

  typedef struct packed {
    logic       rst_n;
    logic       clk;
    logic       frame_n;
    logic [3:0] lad;
  } lpc_pins_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic [7:0]  wdata;
  } ahb_req_t;
endpackage

// ### lpc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host chipset model: runs lpc cycles, clock stands still between frames
module lpc_host_model (
  input  wire logic [3:0] i_dev_lad,
  input  wire logic       i_dev_oe,
  output logic            o_lclk,
  output logic            o_lframe_n,
  output logic      [3:0] o_lad
);
  logic [3:0] host_lad;
  logic       host_oe;
  // lad has pull-ups, so a released bus reads all ones
  assign o_lad = i_dev_oe ? i_dev_lad : (host_oe ? host_lad : 4'hf);
  initial begin
    o_lclk = 1'b1;
    o_lframe_n = 1'b1;
    host_lad = 4'hf;
    host_oe = 1'b0;
  end
  // one clock period; callers change signals just after the rise
  task automatic tick();
    #200 o_lclk = 1'b0;
    #200 o_lclk = 1'b1;
  endtask
  task automatic put(input logic [3:0] n);
    host_lad = n;
    tick();
  endtask
  // typ: 0 io read, 2 io write, 4 mem read, 6 mem write
  task automatic cycle(input logic [3:0] typ, input logic [31:0] a, input int nib,
                       input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int k;
    rd = 8'h00;
    ok = 1'b0;
    host_oe = 1'b1;
    o_lframe_n = 1'b0;
    put(4'h0);
    o_lframe_n = 1'b1;
    put(typ);
    // address msb nibble first, data low nibble first
    for (k = nib - 1; k >= 0; k--) put(a[4*k +: 4]);
    if (typ[1]) begin
      put(wd[3:0]);
      put(wd[7:4]);
    end
    put(4'hf);
    host_oe = 1'b0;
    // a long-wait sync keeps the loop going; no answer within 40 clocks means unclaimed
    for (k = 0; k < 40 && !ok; k++) begin
      tick();
      ok = (o_lad === 4'h0);
    end
    if (ok && !typ[1]) begin
      tick();
      rd[3:0] = o_lad;
      tick();
      rd[7:4] = o_lad;
    end
    tick();
  endtask
endmodule // lpc_host_model

// ### testbench.sv
`timescale 1ns/1ps
// ==========================================================
// bench: config port and memory decode through host bus cycles
module testbench;
  logic        i_clk_sys, i_rst, host_rst_n, lclk, lframe_n, dev_oe, hready, setup;
  logic        hwrite, cap_wr, dph, ok;
  wire  [3:0]  lad_w;
  logic [3:0]  dev_lad;
  logic [23:0] haddr, cap_addr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  hwdata, hrdata, cap_wdata, rd, ahb_rd;
  logic [15:0] base;
  int          wcnt, ahb_wait, ahb_cnt, error_cnt, num_checks;

  lpc_bar_decode lpc_bar_decode_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_host_side_reset_n(host_rst_n),
    .i_lclk(lclk), .i_lframe_n(lframe_n), .i_lad(lad_w), .o_lad(dev_lad),
    .o_lad_oe(dev_oe), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata), .i_hrdata(hrdata), .i_hready(hready),
    .o_setup_active(setup));
  lpc_host_model lpc_host_model_inst (
    .i_dev_lad(dev_lad), .i_dev_oe(dev_oe), .o_lclk(lclk), .o_lframe_n(lframe_n),
    .o_lad(lad_w));

  always #25 i_clk_sys = ~i_clk_sys;

  // ==========================================================
  // internal bus slave with optional wait states
  always begin
    @(posedge i_clk_sys);
    if (dph && hready) begin
      cap_wdata = hwdata;
      dph = 1'b0;
    end
    if (hready && htrans === lpc_bar_pkg::HT_NONSEQ) begin
      cap_addr = haddr;
      cap_wr = hwrite;
      dph = 1'b1;
      wcnt = ahb_wait;
      ahb_cnt++;
    end
    #5;
    hready = !(dph && wcnt > 0);
    if (!hready) wcnt--;
    // read data only meaningful in the data phase; elsewhere it is the inverse of ahb_rd
    hrdata = dph ? ahb_rd : ~ahb_rd;
  end

  // ==========================================================
  // access tasks and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [3:0] typ, input logic [31:0] a, input logic [7:0] d);
    lpc_host_model_inst.cycle(typ, a, typ[2] ? 8 : 4, d, rd, ok);
  endtask
  task automatic cfg_wr(input logic [7:0] p, input logic [7:0] d);
    xfer(4'h2, {16'h0, base}, p);
    xfer(4'h2, {16'h0, base + 16'h1}, d);
  endtask
  task automatic cfg_rd(input logic [7:0] p);
    xfer(4'h2, {16'h0, base}, p);
    xfer(4'h0, {16'h0, base + 16'h1}, 8'h00);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard: the sequence needs well under 2 ms
  initial begin
    #4000000;
    error_cnt++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    int i;
    int j;
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    host_rst_n = 1'b1;
    hready = 1'b1;
    hrdata = 8'h00;
    dph = 1'b0;
    wcnt = 0;
    ahb_wait = 0;
    ahb_cnt = 0;
    ahb_rd = 8'h00;
    error_cnt = 0;
    num_checks = 0;
    base = 16'h002e;
    repeat (12) @(posedge i_clk_sys);
    #5 i_rst = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    #5 xfer(4'h2, 32'h2e, lpc_bar_pkg::SETUP_ENTER);
    chk(ok, 1'b1);
    chk(setup, 1'b1);
    xfer(4'h0, 32'h2e, 8'h00);
    chk(rd, lpc_bar_pkg::SETUP_ENTER);
    // every byte of every decode register at its reset value
    for (i = 0; i < lpc_bar_pkg::N_IO; i++) for (j = 0; j < 4; j++) begin
      cfg_rd(lpc_bar_pkg::IO_OFS[i] + 8'(j));
      chk(rd, lpc_bar_pkg::IO_RST[i][8*j +: 8]);
    end
    for (i = 0; i < lpc_bar_pkg::N_MEM; i++) for (j = 0; j < 6; j++) begin
      cfg_rd(lpc_bar_pkg::MEM_OFS[i] + 8'(j));
      chk(rd, lpc_bar_pkg::MEM_RST[i][8*j +: 8]);
    end
    // relocation: low byte alone must not move the port
    cfg_wr(8'h62, 8'h4e);
    xfer(4'h0, 32'h2e, 8'h00);
    chk(ok, 1'b1);
    cfg_wr(8'h63, 8'h00);
    xfer(4'h0, 32'h2e, 8'h00);
    chk(ok, 1'b0);
    base = 16'h004e;
    cfg_rd(8'h62);
    chk(rd, 8'h4e);
    // host side reset brings the port back to its default base
    host_rst_n = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    #5 host_rst_n = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    #5 base = 16'h002e;
    // setup state was dropped: window writes are lost and reads give zero
    cfg_wr(8'h79, 8'h81);
    cfg_rd(8'h62);
    chk(rd, 8'h00);
    xfer(4'h2, 32'h2e, lpc_bar_pkg::SETUP_ENTER);
    chk(ok, 1'b1);
    cfg_rd(8'h79);
    chk(rd, 8'h01);
    // memory decode of host ec channel 0 at host address 1234_5600
    for (j = 0; j < 4; j++) cfg_wr(8'hc8 + 8'(j), 8'(32'h12345600 >> (8 * j)));
    xfer(4'h4, 32'h12345600, 8'h00);
    chk(ok, 1'b0);
    // a memory cycle at the port base must never reach the config port
    xfer(4'h4, 32'h2e, 8'h00);
    chk(ok, 1'b0);
    cfg_wr(8'hc7, 8'h83);
    ahb_cnt = 0;
    xfer(4'h6, 32'h12345604, 8'ha5);
    chk(ok, 1'b1);
    chk(cap_addr, 24'h000c04);
    chk({cap_wr, cap_wdata}, 9'h1a5);
    chk(hsize, lpc_bar_pkg::HSIZE_BYTE);
    // slow slave: long enough that the device has to answer with long-wait syncs
    ahb_wait = 20;
    ahb_rd = 8'h3c;
    xfer(4'h4, 32'h12345600, 8'h00);
    chk(rd, 8'h3c);
    chk(ahb_cnt, 2);
    xfer(4'h4, 32'h12345602, 8'h00);
    chk(ok, 1'b0);
    // ignore field writable only for unit 3h
    cfg_wr(8'hc6, 8'h0f);
    xfer(4'h4, 32'h12345602, 8'h00);
    chk(cap_addr, 24'h000c02);
    cfg_wr(8'hcc, 8'hff);
    cfg_rd(8'hcc);
    chk(rd, 8'h07);
    // legacy keyboard unit claims by its own fixed range once valid
    cfg_wr(8'h79, 8'h81);
    ahb_rd = 8'h11;
    xfer(4'h0, 32'h64, 8'h00);
    chk(ok, 1'b1);
    chk(cap_addr, 24'h000404);
    end_sim();
  end
endmodule // testbench
